// >>> core/sscg_supervisor.sv
// File: supply supervisor with reset generation, chip-enable gating, backup control.
// Assumes analogue comparators deliver synchronous flags; single 100 MHz clock.
//
// Behaviour
// - Main supply feeds switched output unless below trip and below backup cell.
// - Backup mode only when below-trip and below-cell flags are both true.
// - Outside reset, chip-enable input passes straight to gated output.
// - Chip-enable high at reset start keeps gated output high all event.
// - Chip-enable low at reset start holds output low 12us, then high.
// - The 12us low hold ends early if chip-enable input goes high.
// - Decoupled gated output is driven inactive high.
// - Backup mode: reset held, indicator high, gate high, other inputs ignored.
// - No start-up from backup cell alone; main supply must come up first.
// - Manual reset low asserts reset, held 150ms after release.
// - Manual reset input debounced so one bouncing press gives one event.
// - Each kick edge or pulse restarts the watchdog timer.
// - Kick static past timeout emits reset pulse of hold length.
// - Watchdog timer cleared on any reset and on each kick edge.
// - Static kick repeats reset pulse one timeout period after each pulse ends.
// - Backup indicator driven high while in backup mode.
// - Auxiliary below-reference flag asserts reset.
// - Reset held at least the hold time after auxiliary flag clears.
// - Supply below trip asserts reset, held 150ms after recovery.
// - Reset output polarity is a build-time option.
`timescale 1ns/1ns
module sscg_supervisor
    import sscg_pkg::*;
#(
    parameter int unsigned KICK_TIMEOUT = KICK_CYCLES,
    parameter int unsigned HOLD         = HOLD_CYCLES,
    parameter int unsigned DEBOUNCE     = DEBOUNCE_CYCLES,
    parameter bit          RESET_ACTIVE_HIGH = 1'b0
)
(
    input  wire logic         i_sys_clk,
    input  wire logic         i_rst,
    input  wire logic         i_clk_en,
    input  wire sscg_inputs_t i_in,
    output logic              o_reset,
    output logic              o_chip_enable_n,
    output logic              o_backup_active_flag,
    output logic              o_switch_to_cell
);

    logic             backup_mode;
    logic             powered_reg;
    logic             mr_stable_reg;
    logic             mr_sample_reg;
    logic [CNT_W-1:0] db_cnt_reg;
    logic             kick_prev_reg;
    logic [CNT_W-1:0] wd_cnt_reg;
    logic             wd_fire_reg;
    logic             supply_src;
    logic             mr_src;
    logic             aux_src;
    logic             supply_hold;
    logic             mr_hold;
    logic             aux_hold;
    logic             wd_hold;
    logic             reset_any;
    logic             reset_prev_reg;
    sscg_ce_state_t   ce_state_reg;
    sscg_ce_state_t   ce_state_next;
    logic [CNT_W-1:0] ce_cnt_reg;
    logic             ce_out_reg;
    logic             kick_edge;
    logic             grace_done;
    logic             ce_out_next;

    // ==========================================================
    // Power state and backup mode
    // ==========================================================
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            powered_reg <= 1'b0;
        else if (i_clk_en && !i_in.supply_below_trip)
            powered_reg <= 1'b1;
    end

    // Backup needs both flags, and a prior main-supply start
    assign backup_mode = powered_reg && i_in.supply_below_trip
                         && i_in.supply_below_cell;
    assign o_switch_to_cell = backup_mode;

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            o_backup_active_flag <= 1'b0;
        else if (i_clk_en)
            o_backup_active_flag <= backup_mode;
    end

    // ==========================================================
    // Manual reset debounce
    // ==========================================================
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            mr_sample_reg <= 1'b1;
            mr_stable_reg <= 1'b1;
            db_cnt_reg    <= CNT_ZERO;
        end
        else if (i_clk_en && !backup_mode)
        begin
            mr_sample_reg <= i_in.manual_reset_n;
            if (mr_sample_reg != mr_stable_reg)
            begin
                if (db_cnt_reg >= CNT_W'(DEBOUNCE))
                begin
                    mr_stable_reg <= mr_sample_reg;
                    db_cnt_reg    <= CNT_ZERO;
                end
                else
                    db_cnt_reg <= db_cnt_reg + CNT_ONE;
            end
            else
                db_cnt_reg <= CNT_ZERO;
        end
    end

    // ==========================================================
    // Watchdog
    // ==========================================================
    assign kick_edge = (i_in.kick_input != kick_prev_reg);

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            kick_prev_reg <= 1'b0;
            wd_cnt_reg    <= CNT_ZERO;
            wd_fire_reg   <= 1'b0;
        end
        else if (i_clk_en)
        begin
            kick_prev_reg <= i_in.kick_input;
            wd_fire_reg   <= 1'b0;
            if (reset_any || backup_mode)
                wd_cnt_reg <= CNT_ZERO;
            else if (kick_edge)
                wd_cnt_reg <= CNT_ZERO;
            else if (wd_cnt_reg >= CNT_W'(KICK_TIMEOUT) - CNT_ONE)
            begin
                wd_cnt_reg  <= CNT_ZERO;
                wd_fire_reg <= 1'b1;
            end
            else
                wd_cnt_reg <= wd_cnt_reg + CNT_ONE;
        end
    end

    // ==========================================================
    // Reset sources and hold timers
    // ==========================================================
    assign supply_src = i_in.supply_below_trip || !powered_reg;
    assign mr_src     = !mr_stable_reg && !backup_mode;
    assign aux_src    = i_in.aux_below_ref && !backup_mode;

    sscg_hold_timer #(.HOLD(HOLD)) u_hold_supply
    (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_ce      (i_clk_en),
        .i_src     (supply_src),
        .o_active  (supply_hold)
    );

    sscg_hold_timer #(.HOLD(HOLD)) u_hold_manual
    (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_ce      (i_clk_en),
        .i_src     (mr_src),
        .o_active  (mr_hold)
    );

    sscg_hold_timer #(.HOLD(HOLD)) u_hold_aux
    (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_ce      (i_clk_en),
        .i_src     (aux_src),
        .o_active  (aux_hold)
    );

    sscg_hold_timer #(.HOLD(HOLD)) u_hold_wd
    (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_ce      (i_clk_en),
        .i_src     (wd_fire_reg),
        .o_active  (wd_hold)
    );

    assign reset_any = supply_hold || mr_hold || aux_hold || wd_hold
                       || backup_mode;

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            o_reset <= RESET_ACTIVE_HIGH;
        else if (i_clk_en)
            o_reset <= RESET_ACTIVE_HIGH ? reset_any : !reset_any;
    end

    // ==========================================================
    // Chip-enable gating
    // ==========================================================
    // Grace interval used up
    assign grace_done = (ce_cnt_reg >= CNT_W'(CE_GRACE_CYCLES) - CNT_ONE);

    always_comb
    begin
        ce_state_next = ce_state_reg;
        case (ce_state_reg)
            CE_PASS:
            begin
                if (reset_any)
                begin
                    if (i_in.chip_enable_n || backup_mode)
                        ce_state_next = CE_BLOCK;
                    else
                        ce_state_next = CE_GRACE;
                end
            end
            CE_GRACE:
            begin
                if (!reset_any)
                    ce_state_next = CE_PASS;
                else if (backup_mode || i_in.chip_enable_n || grace_done)
                    ce_state_next = CE_BLOCK;
            end
            CE_BLOCK:
            begin
                if (!reset_any)
                    ce_state_next = CE_PASS;
            end
            default:
            begin
                ce_state_next = CE_BLOCK;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            ce_state_reg <= CE_BLOCK;
        else if (i_clk_en)
            ce_state_reg <= ce_state_next;
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            ce_cnt_reg <= CNT_ZERO;
        else if (i_clk_en)
        begin
            if (ce_state_next == CE_GRACE && ce_state_reg == CE_GRACE)
                ce_cnt_reg <= ce_cnt_reg + CNT_ONE;
            else
                ce_cnt_reg <= CNT_ZERO;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            ce_out_reg <= 1'b1;
        else if (i_clk_en)
            ce_out_reg <= ce_out_next;
    end

    // Gated output level for the coming cycle
    always_comb
    begin
        ce_out_next = 1'b1;
        case (ce_state_next)
            CE_PASS:
            begin
                ce_out_next = i_in.chip_enable_n;
            end
            CE_GRACE:
            begin
                ce_out_next = 1'b0;
            end
            CE_BLOCK:
            begin
                ce_out_next = 1'b1;
            end
            default:
            begin
                ce_out_next = 1'b1;
            end
        endcase
    end

    assign o_chip_enable_n = ce_out_reg;

endmodule

// >>> shared/sscg_pkg.sv
// Package: shared constants and carrier types for the supply supervisor block.
// Assumes a 100 MHz system clock.
package sscg_pkg;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int unsigned CLK_MHZ          = 100;
    localparam int unsigned HOLD_TIME_MS     = 150;
    localparam int unsigned CE_GRACE_US      = 12;
    localparam int unsigned KICK_TIMEOUT_MS  = 1600;
    localparam int unsigned DEBOUNCE_US      = 10000;
    localparam int unsigned HOLD_CYCLES      = HOLD_TIME_MS * 1000 * CLK_MHZ;
    localparam int unsigned CE_GRACE_CYCLES  = CE_GRACE_US * CLK_MHZ;
    localparam int unsigned KICK_CYCLES      = KICK_TIMEOUT_MS * 1000 * CLK_MHZ;
    localparam int unsigned DEBOUNCE_CYCLES  = DEBOUNCE_US * CLK_MHZ;
    localparam int          CNT_W            = 32;

    // ==========================================================
    // Counter constants
    // ==========================================================
    localparam logic [CNT_W-1:0] CNT_ZERO    = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_ONE     = 32'h0000_0001;

    // ==========================================================
    // Carrier types
    // ==========================================================
    typedef struct packed {
        logic supply_below_trip;
        logic supply_below_cell;
        logic aux_below_ref;
        logic manual_reset_n;
        logic kick_input;
        logic chip_enable_n;
    } sscg_inputs_t;

    typedef enum logic [1:0] {
        CE_PASS,
        CE_GRACE,
        CE_BLOCK
    } sscg_ce_state_t;

endpackage

// >>> core/sscg_hold_timer.sv
// File: one reset source with its own restartable hold interval.
// Assumes a synchronous source level and the shared system clock.
`timescale 1ns/1ns
module sscg_hold_timer
    import sscg_pkg::*;
#(
    parameter int unsigned HOLD = HOLD_CYCLES
)
(
    input  wire logic i_sys_clk,
    input  wire logic i_rst,
    input  wire logic i_ce,
    input  wire logic i_src,
    output logic      o_active
);

    logic [CNT_W-1:0] cnt_reg;

    // ==========================================================
    // Hold counter, reloaded while source stands
    // ==========================================================
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            cnt_reg <= CNT_ZERO;
        else if (i_ce)
        begin
            if (i_src)
                cnt_reg <= CNT_W'(HOLD);
            else if (cnt_reg != CNT_ZERO)
                cnt_reg <= cnt_reg - CNT_ONE;
        end
    end

    assign o_active = i_src || (cnt_reg != CNT_ZERO);

endmodule

// >>> sim/sscg_sup_asserts.sv
// Checker: port assertions for the supply supervisor.
// Assumes the supervisor's own polarity parameter is passed by the bind.
`timescale 1ns/1ns
module sscg_sup_asserts
    import sscg_pkg::*;
#(
    parameter int unsigned KICK_TIMEOUT      = KICK_CYCLES,
    parameter int unsigned HOLD              = HOLD_CYCLES,
    parameter int unsigned DEBOUNCE          = DEBOUNCE_CYCLES,
    parameter bit          RESET_ACTIVE_HIGH = 1'b0
)
(
    input wire logic         i_sys_clk,
    input wire logic         i_rst,
    input wire logic         i_clk_en,
    input wire sscg_inputs_t i_in,
    input wire logic         o_reset,
    input wire logic         o_chip_enable_n,
    input wire logic         o_backup_active_flag,
    input wire logic         o_switch_to_cell
);
    // ==========
    // Helpers
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    wire logic   on = (o_reset == RESET_ACTIVE_HIGH);
    logic [31:0] run_reg;
    logic [31:0] low_reg;
    logic [31:0] quiet_reg;
    logic        kick_d_reg;
    always_ff @(posedge i_sys_clk or posedge i_rst)
        if (i_rst) run_reg <= 32'h0;
        else run_reg <= on ? run_reg + 32'h1 : 32'h0;
    always_ff @(posedge i_sys_clk or posedge i_rst)
        if (i_rst) low_reg <= 32'h0;
        else low_reg <= (on && !o_chip_enable_n) ? low_reg + 32'h1 : 32'h0;
    always_ff @(posedge i_sys_clk or posedge i_rst)
        if (i_rst)
        begin
            kick_d_reg <= 1'b0;
            quiet_reg  <= 32'h0;
        end
        else
        begin
            kick_d_reg <= i_in.kick_input;
            quiet_reg  <= (on || i_in.kick_input != kick_d_reg) ? 32'h0 : quiet_reg + 32'h1;
        end
    // ==========
    // Assertions
    hold_min_a: assert property ($fell(on) |-> run_reg >= HOLD)
        else $error("reset released before hold time");
    grace_max_a: assert property (low_reg <= CE_GRACE_CYCLES + 2)
        else $error("gated enable low too long in reset");
    grace_hold_a: assert property ($rose(on) && !o_chip_enable_n && !i_in.chip_enable_n
        && !i_in.supply_below_cell |=> !o_chip_enable_n) else $error("grace cut short");
    ce_stay_a: assert property (on && $past(on) && $past(o_chip_enable_n) |-> o_chip_enable_n)
        else $error("gated enable fell during reset");
    ce_early_a: assert property (on && $past(i_in.chip_enable_n) |-> o_chip_enable_n)
        else $error("gated enable low after input high");
    ce_pass_a: assert property (!on && !$past(on) && !$past(on, 2) && $past(i_clk_en)
        |-> o_chip_enable_n == $past(i_in.chip_enable_n)) else $error("enable not passed");
    bk_safe_a: assert property (o_backup_active_flag |-> on && o_chip_enable_n)
        else $error("backup without reset and gate");
    bk_cause_a: assert property (o_backup_active_flag |-> $past(i_in.supply_below_trip))
        else $error("backup flag without low supply");
    bk_off_a: assert property ($past(i_clk_en) && !$past(i_in.supply_below_trip)
        |-> !o_backup_active_flag)
        else $error("backup flag high with good supply");
    sw_cause_a: assert property (o_switch_to_cell |-> i_in.supply_below_trip
        && i_in.supply_below_cell) else $error("cell selected wrongly");
    kick_to_a: assert property (quiet_reg <= KICK_TIMEOUT + 4)
        else $error("watchdog did not fire");
endmodule

bind sscg_supervisor sscg_sup_asserts #(.KICK_TIMEOUT(KICK_TIMEOUT), .HOLD(HOLD),
    .DEBOUNCE(DEBOUNCE), .RESET_ACTIVE_HIGH(RESET_ACTIVE_HIGH)) u_chk (.*);

// >>> sim/sscg_cpu_model.sv
// Model: processor side, toggles the kick line at a fixed gap.
// Assumes the bench system clock.
`timescale 1ns/1ns
module sscg_cpu_model
#(
    parameter int GAP = 40
)
(
    input  wire logic i_sys_clk,
    input  wire logic i_run,
    output logic      o_kick
);
    int cnt = 0;
    initial o_kick = 1'b0;
    always @(posedge i_sys_clk)
    begin
        cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
        if (i_run && cnt == GAP - 1)
            o_kick <= #1 ~o_kick;
    end
endmodule

// >>> sim/tb.sv
// Testbench: self-checking run of the supply supervisor.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ns
module tb
    import sscg_pkg::*;
;
    // ==========
    // Setup
    localparam int HOLD = 50;
    localparam int KT   = 200;
    typedef struct packed {logic [4:0] f; logic [7:0] n; logic [3:0] e;} sscg_row_t;
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    logic         run = 1'b1;
    logic         clk_en = 1'b1;
    logic         kick;
    logic [4:0]   f = 5'b11011;
    logic         rst_o, ce_o, bk_o, sw_o;
    int           bad_count = 0;
    int           checks_done = 0;
    int           n;
    wire logic    on = ~rst_o;
    wire sscg_inputs_t in_w = {f[4:1], kick, f[0]};
    sscg_row_t rows [14] = '{
        '{5'b00011, 80, 4'b0100}, '{5'b10011, 10, 4'b1100}, '{5'b00011, 30, 4'b1100},
        '{5'b00011, 40, 4'b0100}, '{5'b00111, 10, 4'b1100}, '{5'b00011, 30, 4'b1100},
        '{5'b00011, 40, 4'b0100}, '{5'b00001, 20, 4'b1100}, '{5'b00011, 30, 4'b1100},
        '{5'b00011, 40, 4'b0100}, '{5'b11011, 5, 4'b1111}, '{5'b11100, 5, 4'b1111},
        '{5'b00011, 100, 4'b0100}, '{5'b00010, 3, 4'b0000}};
    sscg_supervisor #(.KICK_TIMEOUT(KT), .HOLD(HOLD), .DEBOUNCE(5)) u_dut (
        .i_sys_clk(clk), .i_rst(rst), .i_clk_en(clk_en), .i_in(in_w), .o_reset(rst_o),
        .o_chip_enable_n(ce_o), .o_backup_active_flag(bk_o), .o_switch_to_cell(sw_o));
    sscg_cpu_model #(.GAP(40)) u_cpu (.i_sys_clk(clk), .i_run(run), .o_kick(kick));
    initial forever #5 clk = ~clk;
    task step(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task chk(input logic [3:0] s, input logic [3:0] e);
        checks_done++;
        if (s !== e)
        begin
            bad_count++;
            $display("BAD t=%0t got %h exp %h", $time, s, e);
        end
    endtask
    task print_verdict();
        $display("checks %0d bad %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task wait_on(input logic v, input int m);
        int k;
        k = 0;
        while (on !== v && k < m)
        begin
            step(1);
            k++;
        end
        if (on !== v)
        begin
            bad_count++;
            print_verdict();
        end
    endtask
    // ==========
    // Sequence
    initial
    begin
        step(5);
        rst = 1'b0;
        step(10);
        chk({2'b00, on, bk_o}, 4'b0010);
        foreach (rows[i])
        begin
            f = rows[i].f;
            step(rows[i].n);
            chk({on, ce_o, bk_o, sw_o}, rows[i].e);
        end
        f = 5'b00110;
        step(3);
        chk({on, ce_o, bk_o, sw_o}, 4'b1000);
        step(1190);
        chk({on, ce_o, bk_o, sw_o}, 4'b1000);
        step(15);
        chk({on, ce_o, bk_o, sw_o}, 4'b1100);
        f = 5'b00111;
        step(2);
        f = 5'b00110;
        step(2);
        chk({on, ce_o, bk_o, sw_o}, 4'b1100);
        f = 5'b00010;
        step(60);
        chk({on, ce_o, bk_o, sw_o}, 4'b0000);
        f = 5'b00110;
        step(50);
        chk({on, ce_o, bk_o, sw_o}, 4'b1000);
        f = 5'b00111;
        step(2);
        chk({on, ce_o, bk_o, sw_o}, 4'b1100);
        f = 5'b00110;
        step(2);
        chk({on, ce_o, bk_o, sw_o}, 4'b1100);
        f = 5'b00011;
        step(60);
        chk({on, ce_o, bk_o, sw_o}, 4'b0100);
        run = 1'b0;
        step(150);
        chk({on, ce_o, bk_o, sw_o}, 4'b0100);
        wait_on(1'b1, 100);
        n = 0;
        while (on && n < 300)
        begin
            step(1);
            n++;
        end
        chk({3'b000, n >= HOLD && n <= HOLD + 2}, 4'b0001);
        step(KT - 10);
        chk({on, ce_o, bk_o, sw_o}, 4'b0100);
        wait_on(1'b1, 30);
        run = 1'b1;
        wait_on(1'b0, 100);
        step(KT + 50);
        chk({on, ce_o, bk_o, sw_o}, 4'b0100);
        repeat (4)
        begin
            f = 5'b00001;
            step(2);
            f = 5'b00011;
            step(2);
        end
        step(10);
        chk({on, ce_o, bk_o, sw_o}, 4'b0100);
        f = 5'b00010;
        clk_en = 1'b0;
        step(5);
        chk({on, ce_o, bk_o, sw_o}, 4'b0100);
        clk_en = 1'b1;
        step(2);
        chk({on, ce_o, bk_o, sw_o}, 4'b0000);
        f = 5'b00011;
        rst = 1'b1;
        step(2);
        chk({on, ce_o, bk_o, sw_o}, 4'b1100);
        rst = 1'b0;
        step(2);
        chk({on, ce_o, bk_o, sw_o}, 4'b1100);
        step(60);
        chk({on, ce_o, bk_o, sw_o}, 4'b0100);
        print_verdict();
    end
endmodule
